// ---- rtl/sdcl_consts.vh ----
// Constants for the serial code loader: widths, decode sizes, reset values.
// Assumes inclusion by bare name from the loader; the FIFO does not include it.
//
// Behaviour
// - Each serial clock rise shifts one bit while select is low, none else.
// - Load select rising queues the shift register's code bits in a buffer that the holding one drains; with the buffer full the frame is dropped.
// - The code is 14 bits with bit 13 on top, sent top bit first.
// - Up to 16 bits may be shifted and only the last 14 are transferred.
// - Top three held bits drive seven equal legs, the rest binary legs.
// - Each leg control is ground or output node, never a third state.
// - Serial data is captured on the rising edge of the serial clock.
// - Leading surplus bits are discarded and never reach the loaded code.
`ifndef SDCL_CONSTS_VH
`define SDCL_CONSTS_VH

// Code and shift register sizes
`define SDCL_CODE_W 14
`define SDCL_SHIFT_W 16
`define SDCL_CODE_MSB 13
`define SDCL_CODE_LSB 0

// Segmented decode of the top bits
`define SDCL_SEG_BITS 3
`define SDCL_SEG_LEGS 7
`define SDCL_BIN_LEGS 11

// Buffering between frame end and holding register
`define SDCL_FIFO_DEPTH 4
`define SDCL_FIFO_AW 2

// Frame bit counter
`define SDCL_CNT_W 5
`define SDCL_CNT_ONE 5'h01
`define SDCL_CNT_MAX 5'h1f

// Reset values
`define SDCL_CODE_RST 14'h0000
`define SDCL_SHIFT_RST 16'h0000
`define SDCL_SEG_RST 7'h00
`define SDCL_BIN_RST 11'h000
`define SDCL_CNT_RST 5'h00

// Pin and pulse reset levels
`define SDCL_PIN_LOW 1'b0
`define SDCL_SEL_IDLE 1'b1
`define SDCL_PULSE_RST 1'b0

`endif

// ---- rtl/sdcl_fifo.v ----
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps

module sdcl_fifo #(
  parameter WIDTH = 14,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk_i,              // System clock
  input wire rst_b_i,            // Synchronous reset, active low
  input wire in_valid_i,         // Word offered
  output wire in_ready_o,        // Room for a word
  input wire [WIDTH-1:0] in_data_i, // Word to store
  output wire out_valid_o,       // Word available
  input wire out_ready_i,        // Drain accepts word
  output wire [WIDTH-1:0] out_data_o // Oldest word
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;

  // Honest full and empty from the fill count
  assign in_ready_o = (count_q != DEPTH[AW:0]);
  assign out_valid_o = (count_q != {(AW+1){1'b0}});
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem_q[rd_ptr_q];

  // Storage write
  always @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  // Pointers wrap at the depth
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                    : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                    : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

// ---- rtl/sdcl_code_loader.v ----
// Serial code loader: shifts a code in from a three-wire link and drives
// the ladder leg switch controls from a holding register.
// Assumes the serial pins are asynchronous to clk_i and that each serial
// clock level lasts at least two clk_i periods.
`timescale 1ns/100ps

`include "sdcl_consts.vh"

module sdcl_code_loader #(
  parameter CODE_W = `SDCL_CODE_W,
  parameter SHIFT_W = `SDCL_SHIFT_W,
  parameter FIFO_DEPTH = `SDCL_FIFO_DEPTH,
  parameter FIFO_AW = `SDCL_FIFO_AW
) (
  input wire clk_i,               // System clock, 125 MHz
  input wire rst_b_i,             // Synchronous reset, active low
  input wire serial_clk_i,        // Serial clock pin
  input wire serial_code_in_i,    // Serial data pin
  input wire load_sel_b_i,        // Load select pin, active low
  input wire update_ready_i,      // Holding register may take a code
  output wire load_ready_o,       // Room for another frame
  output reg load_drop_o,         // Frame lost, buffer full
  output reg load_short_o,        // Frame had fewer than code bits
  output reg code_update_o,       // Holding register just loaded
  output wire [CODE_W-1:0] code_o, // Held code
  output wire code_top_bit_o,     // Held code, top bit
  output wire code_bottom_bit_o,  // Held code, bottom bit
  output wire [`SDCL_SEG_LEGS-1:0] seg_legs_o, // Equal-weight legs
  output wire [CODE_W-`SDCL_SEG_BITS-1:0] bin_legs_o // Binary legs
);

  // Width of the binary-weighted part of the code
  localparam BIN_W = CODE_W - `SDCL_SEG_BITS;

  // Pin synchronisers and edge history
  reg sclk_meta_q;
  reg sclk_sync_q;
  reg sclk_prev_q;
  reg sel_meta_q;
  reg sel_sync_q;
  reg sel_prev_q;
  reg sdi_meta_q;
  reg sdi_sync_q;

  // Shift path
  reg [SHIFT_W-1:0] shift_q;
  reg [SHIFT_W-1:0] shift_d;
  reg [`SDCL_CNT_W-1:0] bits_q;
  reg [`SDCL_CNT_W-1:0] bits_d;

  // Holding register and leg drivers
  reg [CODE_W-1:0] code_q;
  reg [`SDCL_SEG_LEGS-1:0] seg_q;
  reg [BIN_W-1:0] bin_q;

  // Edge strobes and buffer outputs
  wire sclk_rise;
  wire sel_rise;
  wire shift_en;
  wire fifo_out_valid;
  wire [CODE_W-1:0] fifo_out_data;
  wire hold_load;
  wire [`SDCL_SEG_LEGS-1:0] seg_next;

  // Serial clock pin: two flops, then edge history
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      sclk_meta_q <= `SDCL_PIN_LOW;
      sclk_sync_q <= `SDCL_PIN_LOW;
      sclk_prev_q <= `SDCL_PIN_LOW;
    end else begin
      sclk_meta_q <= serial_clk_i;
      sclk_sync_q <= sclk_meta_q;
      sclk_prev_q <= sclk_sync_q;
    end
  end

  // Select pin resets to its idle level, so no false rise after reset
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      sel_meta_q <= `SDCL_SEL_IDLE;
      sel_sync_q <= `SDCL_SEL_IDLE;
      sel_prev_q <= `SDCL_SEL_IDLE;
    end else begin
      sel_meta_q <= load_sel_b_i;
      sel_sync_q <= sel_meta_q;
      sel_prev_q <= sel_sync_q;
    end
  end

  // Data pin: two flops, same latency as the clock path
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      sdi_meta_q <= `SDCL_PIN_LOW;
      sdi_sync_q <= `SDCL_PIN_LOW;
    end else begin
      sdi_meta_q <= serial_code_in_i;
      sdi_sync_q <= sdi_meta_q;
    end
  end

  assign sclk_rise = sclk_sync_q & ~sclk_prev_q;
  // select returning high ends a frame
  assign sel_rise = sel_sync_q & ~sel_prev_q;
  // shift only while select is low
  assign shift_en = sclk_rise & ~sel_sync_q;

  // Next shift contents and frame bit count
  always @* begin
    shift_d = shift_q;
    bits_d = bits_q;
    if (shift_en) begin
      // earlier bits move up, first bit ends on top
      shift_d = {shift_q[SHIFT_W-2:0], sdi_sync_q};
      if (bits_q != `SDCL_CNT_MAX) begin
        bits_d = bits_q + `SDCL_CNT_ONE;
      end
    end else if (sel_rise) begin
      bits_d = `SDCL_CNT_RST;
    end
  end

  // Shift register update
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      shift_q <= `SDCL_SHIFT_RST;
    end else begin
      shift_q <= shift_d;
    end
  end

  // Frame bit counter update
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      bits_q <= `SDCL_CNT_RST;
    end else begin
      bits_q <= bits_d;
    end
  end

  // Frame lost: select rose while the buffer was full
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      load_drop_o <= `SDCL_PULSE_RST;
    end else begin
      load_drop_o <= sel_rise & ~load_ready_o;
    end
  end

  // Short frame: fewer shifts than code bits
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      load_short_o <= `SDCL_PULSE_RST;
    end else begin
      load_short_o <= sel_rise & (bits_q < CODE_W[`SDCL_CNT_W-1:0]);
    end
  end

  // only the newest code bits enter the buffer
  // older leading bits are left behind
  sdcl_fifo #(
    .WIDTH(CODE_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(sel_rise),
    .in_ready_o(load_ready_o),
    .in_data_i(shift_q[CODE_W-1:0]),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(update_ready_i),
    .out_data_o(fifo_out_data)
  );

  // the oldest buffered code moves to the holding register
  assign hold_load = fifo_out_valid & update_ready_i;

  // thermometer decode of the top bits
  genvar k;
  generate
    for (k = 0; k < `SDCL_SEG_LEGS; k = k + 1) begin : g_seg
      localparam [`SDCL_SEG_BITS-1:0] LEG_IDX = k;
      assign seg_next[k] =
        (fifo_out_data[CODE_W-1:BIN_W] > LEG_IDX);
    end
  endgenerate

  // holding register keeps its value, zero after reset
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      code_q <= `SDCL_CODE_RST;
    end else if (hold_load) begin
      code_q <= fifo_out_data;
    end
  end

  // Load strobe, set by the same edge that loads the code
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      code_update_o <= `SDCL_PULSE_RST;
    end else begin
      code_update_o <= hold_load;
    end
  end

  // Leg switch drivers load together with the code
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      seg_q <= `SDCL_SEG_RST;
      bin_q <= `SDCL_BIN_RST;
    end else if (hold_load) begin
      seg_q <= seg_next;
      // lower bits each drive one binary leg
      bin_q <= fifo_out_data[BIN_W-1:0];
    end
  end

  // two-state leg controls, 1 steers to output node
  assign seg_legs_o = seg_q;
  assign bin_legs_o = bin_q;
  assign code_o = code_q;
  // top and bottom bits of the held code
  assign code_top_bit_o = code_q[`SDCL_CODE_MSB];
  assign code_bottom_bit_o = code_q[`SDCL_CODE_LSB];

endmodule

// ---- verification/sdcl_host.sv ----
// Host model: writes frames on the three-wire serial link.
// Assumes the bench clock; pins move on its falling edge.
`timescale 1ns/100ps
module sdcl_host (
  input logic clk_i, // Bench clock
  output logic serial_clk_o = 0, // Serial clock, idle low
  output logic serial_code_in_o = 0, // Serial data
  output logic load_sel_b_o = 1 // Load select
);
  // Wait falling edges
  task automatic w(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // One serial clock pulse, levels of four cycles
  task automatic tick();
    w(4);
    serial_clk_o = 1;
    w(4);
    serial_clk_o = 0;
  endtask
  task automatic send(input logic [15:0] d, input int n);
    load_sel_b_o = 0;
    for (int i = 0; i < n; i++) begin
      serial_code_in_o = d[15-i];
      tick();
    end
    w(4);
    load_sel_b_o = 1;
    serial_code_in_o = ~serial_code_in_o; // Data line toggled after the frame
    w(4);
  endtask
  // Clock pulses with select high
  task automatic idle(input int n);
    serial_code_in_o = 1;
    repeat (n) tick();
    w(4);
  endtask
endmodule

// ---- verification/sdcl_code_loader_assertions.sv ----
// Checker of the loader's outputs against its inputs.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module sdcl_code_loader_assertions #(
  parameter CODE_W = 14
) (
  input logic clk_i, // Clock
  input logic rst_b_i, // Reset
  input logic update_ready_i, // Drain enable
  input logic load_ready_o, // Buffer room
  input logic load_drop_o, // Frame lost
  input logic load_short_o, // Short frame
  input logic code_update_o, // Load pulse
  input logic [CODE_W-1:0] code_o, // Held code
  input logic code_top_bit_o, // Top bit
  input logic code_bottom_bit_o, // Bottom bit
  input logic [6:0] seg_legs_o, // Equal legs
  input logic [CODE_W-4:0] bin_legs_o // Binary legs
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Drain held off
  sequence s_quiet;
    !update_ready_i [*3];
  endsequence
  // Drain was open, and the load strobe stands with the new code
  sequence s_load;
    $past(update_ready_i) && code_update_o;
  endsequence
  chk_end_bits: assert property (
    code_top_bit_o == code_o[CODE_W-1] && code_bottom_bit_o == code_o[0])
    else $error("end bits differ from code");
  chk_bin_legs: assert property (bin_legs_o == code_o[CODE_W-4:0])
    else $error("binary legs differ from code");
  chk_seg_legs: assert property (
    seg_legs_o == ~(7'h7f << code_o[CODE_W-1 -: 3]))
    else $error("segment legs wrong");
  chk_load_flag: assert property ($changed(code_o) |-> s_load)
    else $error("load not flagged");
  chk_hold_code: assert property (s_quiet |-> $stable(code_o))
    else $error("code moved while stalled");
  chk_no_flag: assert property (s_quiet |=> !code_update_o)
    else $error("flag while stalled");
  chk_drop_full: assert property (load_drop_o |-> !$past(load_ready_o))
    else $error("drop with room");
  chk_pulse_once: assert property (
    load_short_o || load_drop_o |=> (!load_short_o && !load_drop_o) [*3])
    else $error("frame pulse too long");
endmodule
bind sdcl_code_loader sdcl_code_loader_assertions #(.CODE_W(CODE_W)) chk (
  .clk_i, .rst_b_i, .update_ready_i, .load_ready_o, .load_drop_o,
  .load_short_o, .code_update_o, .code_o, .code_top_bit_o,
  .code_bottom_bit_o, .seg_legs_o, .bin_legs_o);

// ---- verification/test_serial_dac_code_loader.sv ----
// Bench for the serial code loader: host frames in, held code out.
// Assumes the host model and checker compile first.
`timescale 1ns/100ps
`define CK(n, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_serial_dac_code_loader;
  logic clk_i = 0, rst_b_i = 0, update_ready_i = 1;
  wire serial_clk_i, serial_code_in_i, load_sel_b_i, load_ready_o;
  wire load_drop_o, load_short_o, code_update_o, code_top_bit_o;
  wire code_bottom_bit_o;
  wire [13:0] code_o;
  wire [6:0] seg_legs_o;
  wire [10:0] bin_legs_o;
  int err_total = 0, n_checks = 0, n_drop = 0, n_short = 0, n_upd = 0;
  logic [13:0] last = 0;
  logic [13:0] got[$];
  initial forever #4 clk_i = ~clk_i;
  sdcl_code_loader dut (.*);
  sdcl_host host (.clk_i, .serial_clk_o(serial_clk_i),
    .serial_code_in_o(serial_code_in_i), .load_sel_b_o(load_sel_b_i));
  // Count pulses, record each new code
  always @(posedge clk_i) begin
    n_drop += (load_drop_o === 1'b1);
    n_short += (load_short_o === 1'b1);
    n_upd += (code_update_o === 1'b1);
    if (code_o !== last) got.push_back(code_o);
    last = code_o;
  end
  task automatic settle();
    repeat (12) @(negedge clk_i);
  endtask
  task automatic t_codes();
    logic [13:0] c;
    `CK("code", 14'h0000, code_o)
    for (int k = 0; k < 8; k++) begin
      c = {k[2:0], 11'h2a5 + 11'(k)};
      host.send({c, 2'b00}, 14);
      settle();
      `CK("code", c, code_o)
      `CK("seg", ~(7'h7f << k), seg_legs_o)
      `CK("bin", c[10:0], bin_legs_o)
      `CK("top", c[13], code_top_bit_o)
      `CK("bottom", c[0], code_bottom_bit_o)
    end
    $display("t_codes done");
  endtask
  task automatic t_long();
    host.send({2'b11, 14'h1234}, 16);
    settle();
    `CK("code", 14'h1234, code_o)
    `CK("top", 1'b0, code_top_bit_o)
    $display("t_long done");
  endtask
  task automatic t_short();
    int s0;
    s0 = n_short;
    host.send({14'h1e5a, 2'b00}, 14);
    host.idle(3);
    host.send(16'h9600, 8);
    settle();
    `CK("code", {6'h1a, 8'h96}, code_o)
    `CK("short", 1, n_short - s0)
    $display("t_short done");
  endtask
  task automatic t_fifo();
    int d0, u0;
    d0 = n_drop;
    u0 = n_upd;
    update_ready_i = 0;
    for (int i = 0; i < 5; i++) host.send({14'h0100 + 14'(i), 2'b00}, 14);
    settle();
    `CK("ready", 1'b0, load_ready_o)
    `CK("drop", 1, n_drop - d0)
    `CK("held", 14'h1a96, code_o)
    got.delete();
    update_ready_i = 1;
    settle();
    `CK("loads", 4, n_upd - u0)
    `CK("first", 14'h0100, got[0])
    `CK("last", 14'h0103, code_o)
    `CK("room", 1'b1, load_ready_o)
    $display("t_fifo done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk_i);
    rst_b_i = 1;
    repeat (4) @(negedge clk_i);
    t_codes();
    t_long();
    t_short();
    t_fifo();
    tally_and_finish();
  end
  // Watchdog
  initial begin
    #60000;
    err_total++;
    tally_and_finish();
  end
endmodule
